// ===== design/pmc_defs.svh
// Function
// [RULE1] Pin readback register shows memory D7, system D2, panel D0 power pin levels.
// [RULE2] Doze code 0 off, 1-8 eighth seconds, 9-15 two to fourteen seconds.
// [RULE3] Sleep code resets to zero meaning off; 1-15 select whole minutes.
// [RULE4] Suspend code zero is off; 1-15 select whole minutes.
// [RULE5] Activity flags set on source activity even when that source is masked.
// [RULE6] Reading activity flags clears them; bit map 7,6,5,3,2,1,0.
// [RULE7] I/O window flag sets on I/O access inside configured window.
// [RULE8] Writing one clears an NMI pending bit; writing zero leaves it.
// [RULE9] NMI output held active while global block is zero and any source pending; the code needs a pending source whose mask bit is clear.
// [RULE10] A source with its mask bit set never raises the NMI.
// [RULE11] Restart waits none, 62.5, 125 or 250 ms after supply good; reset 250.
// [RULE12] Low battery beep enable gives one beep when a wake request is ignored.
// [RULE13] Power good beep enable gives two beeps when a wake is cancelled.
// [RULE14] Wake inhibit drops wake requests while low battery input is active.
// [RULE15] Low battery cancel aborts wake if first low battery rises before supply good.
// [RULE16] Power good cancel aborts wake if supply good absent one second after power.
// [RULE17] Clock halt conditions act only while the master enable bit is one.
// [RULE18] Halt on bus grant stops CPU clock while refresh or display holds bus.
// [RULE19] Halt on expansion cycle stops clock from cycle start until internal ready.
// [RULE20] Halt on CPU halt stops clock until interrupt, NMI or hold request.
// [RULE21] I/O window throttle mask resets to one; zero makes window hits throttle activity.
// [RULE22] Window is 16 bytes when size bit zero, 8 when one, on address bits 9..3.
// [RULE23] Global NMI block resets to one and blocks delivery, not pending capture.
// [RULE24] Idle timers restart on unmasked activity and expire after a quiet interval.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PMC_IDX_NMI_MASK 10'h0C4
`define PMC_IDX_IO_WINDOW 10'h0C5
`define PMC_IDX_PIN_READBACK 10'h0CB
`define PMC_IDX_DOZE 10'h0CC
`define PMC_IDX_SLEEP 10'h0CD
`define PMC_IDX_SUSPEND 10'h0CE
`define PMC_IDX_ACTIVITY 10'h0DB
`define PMC_IDX_NMI_PENDING 10'h0DC
`define PMC_IDX_RESUME 10'h0DD
`define PMC_IDX_CLOCK_STOP 10'h0DE
`define PMC_IDX_THROTTLE_MASK 10'h0DF

// Writable bit masks and reset values.
`define PMC_MASK_TIMER 8'h0F
`define PMC_MASK_NMI_MASK 8'hBE
`define PMC_MASK_RESUME 8'hFE
`define PMC_MASK_CLOCK_STOP 8'h87
`define PMC_MASK_THROTTLE 8'h80
`define PMC_RST_NMI_MASK 8'hBE
`define PMC_RST_RESUME 8'hC0
`define PMC_RST_THROTTLE 8'h80

// Field positions.
`define PMC_BIT_MEMORY_PIN 7
`define PMC_BIT_SYSTEM_PIN 2
`define PMC_BIT_PANEL_PIN 0
`define PMC_BIT_GLOBAL_NMI_BLOCK 7
`define PMC_BIT_WINDOW_SIZE 7
`define PMC_BIT_BEEP_LB 5
`define PMC_BIT_BEEP_PWG 4
`define PMC_BIT_WAKE_INHIBIT 3
`define PMC_BIT_LB_CANCEL 2
`define PMC_BIT_PWG_CANCEL 1
`define PMC_BIT_HALT_ENABLE 7
`define PMC_BIT_HALT_GRANT 2
`define PMC_BIT_HALT_EXPANSION 1
`define PMC_BIT_HALT_CPU 0
`define PMC_BIT_WINDOW_THROTTLE 7

// Timing, in nanoseconds, the clock period, and timer scale counts.
`define PMC_CLK_NS 20
`define PMC_EIGHTH_NS 125000000
`define PMC_DELAY1_NS 62500000
`define PMC_DELAY2_NS 125000000
`define PMC_DELAY3_NS 250000000
`define PMC_PWG_TIMEOUT_NS 1000000000
`define PMC_EIGHTHS_PER_MIN 16'h01E0
`define PMC_DOZE_FINE_LAST 16'h0008

`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

// ===== design/pmc_pkg.sv
package pmc_pkg;

  typedef enum logic [1:0] {
    RS_OFF,
    RS_POWER_UP,
    RS_DELAY,
    RS_ON
  } pmc_resume_e;

  typedef logic [9:0] pmc_index_t;

endpackage

// ===== design/pmc_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pmc_defs.svh"

module pmc_top
  import pmc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int unsigned EIGHTH_CYC = `PMC_EIGHTH_NS / `PMC_CLK_NS,
  parameter int unsigned DELAY1_CYC = `PMC_DELAY1_NS / `PMC_CLK_NS,
  parameter int unsigned DELAY2_CYC = `PMC_DELAY2_NS / `PMC_CLK_NS,
  parameter int unsigned DELAY3_CYC = `PMC_DELAY3_NS / `PMC_CLK_NS,
  parameter int unsigned PWG_TIMEOUT_CYC = `PMC_PWG_TIMEOUT_NS / `PMC_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power pin levels
  input wire logic memoryPowerPin,
  input wire logic systemPowerPin,
  input wire logic panelPowerPin,
  // Activity sources
  input wire logic ioCycle,
  input wire logic [9:0] ioAddr,
  input wire logic videoAccess,
  input wire logic diskAccess,
  input wire logic serialAccess,
  input wire logic cardAccess,
  input wire logic keyboardAccess,
  input wire logic pinSelectAccess,
  // NMI sources
  input wire logic sleepWakeEvent,
  input wire logic firstLowBatteryInput,
  input wire logic secondLowBatteryInput,
  input wire logic externalPinInput,
  // Resume sequencing
  input wire logic resumeRequest,
  input wire logic suspendRequest,
  input wire logic lowBatteryInput,
  input wire logic supplyGoodInput,
  // CPU clock stop sources
  input wire logic haltCycle,
  input wire logic busGranted,
  input wire logic expansionStart,
  input wire logic internalReady,
  input wire logic interruptRequest,
  input wire logic busHoldRequest,
  // Outputs
  output logic nmiOut,
  output logic throttleActivity,
  output logic dozeExpired,
  output logic sleepExpired,
  output logic suspendExpired,
  output logic systemPowerRequest,
  output logic cpuRestart,
  output logic beepOnce,
  output logic beepTwice,
  output logic cpuClockStop
);

  function automatic pmc_index_t regIndex(input logic [ADDR_W-1:0] addr);
    regIndex = addr[11:2];
  endfunction

  // Eighth-second ticks to expiry for a doze code.
  function automatic logic [15:0] dozeTarget(input logic [3:0] code);
    dozeTarget = (code <= `PMC_DOZE_FINE_LAST) ? {12'h0, code} : // RULE2
                 ({12'h0, code} - `PMC_DOZE_FINE_LAST) << 4;
  endfunction

  function automatic logic [15:0] minuteTarget(input logic [3:0] code);
    minuteTarget = {12'h000, code} * `PMC_EIGHTHS_PER_MIN;
  endfunction

  function automatic logic [31:0] restartCycles(input logic [1:0] sel);
    case (sel)
      2'h0: restartCycles = 32'h0;
      2'h1: restartCycles = DELAY1_CYC;
      2'h2: restartCycles = DELAY2_CYC;
      default: restartCycles = DELAY3_CYC;
    endcase
  endfunction

  logic [7:0] nmiMaskReg, ioWindowReg, dozeReg, sleepReg, suspendReg;
  logic [7:0] activityReg, nmiPendingReg, resumeReg, clockStopReg, throttleReg;
  logic awHeld, wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic doWrite, doRead;
  pmc_index_t wIdx, rIdx;
  logic [7:0] readValue;
  logic readHit, writeHit;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign wIdx = regIndex(awAddrHeld);
  assign rIdx = regIndex(s_axi_araddr);

  // Write channel: address and data are taken in either order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= '0;
      wDataHeld <= 32'h0;
      wStrbHeld <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrHeld <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataHeld <= s_axi_wdata;
        wStrbHeld <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeHit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // The readback register is read-only, so a write to it is refused.
  assign writeHit = (wIdx == `PMC_IDX_NMI_MASK) || (wIdx == `PMC_IDX_IO_WINDOW) ||
                    (wIdx >= `PMC_IDX_DOZE && wIdx <= `PMC_IDX_SUSPEND) ||
                    (wIdx >= `PMC_IDX_ACTIVITY && wIdx <= `PMC_IDX_THROTTLE_MASK);

  logic byteWrite;
  assign byteWrite = doWrite && wStrbHeld[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiMaskReg <= `PMC_RST_NMI_MASK; // RULE23
      ioWindowReg <= 8'h00;
      dozeReg <= 8'h00;
      sleepReg <= 8'h00; // RULE3
      suspendReg <= 8'h00;
      resumeReg <= `PMC_RST_RESUME; // RULE11
      clockStopReg <= 8'h00;
      throttleReg <= `PMC_RST_THROTTLE; // RULE21
    end else if (byteWrite) begin
      if (wIdx == `PMC_IDX_NMI_MASK) begin
        nmiMaskReg <= wDataHeld[7:0] & `PMC_MASK_NMI_MASK;
      end else if (wIdx == `PMC_IDX_IO_WINDOW) begin
        ioWindowReg <= wDataHeld[7:0];
      end else if (wIdx == `PMC_IDX_DOZE) begin
        dozeReg <= wDataHeld[7:0] & `PMC_MASK_TIMER;
      end else if (wIdx == `PMC_IDX_SLEEP) begin
        sleepReg <= wDataHeld[7:0] & `PMC_MASK_TIMER;
      end else if (wIdx == `PMC_IDX_SUSPEND) begin
        suspendReg <= wDataHeld[7:0] & `PMC_MASK_TIMER;
      end else if (wIdx == `PMC_IDX_RESUME) begin
        resumeReg <= wDataHeld[7:0] & `PMC_MASK_RESUME;
      end else if (wIdx == `PMC_IDX_CLOCK_STOP) begin
        clockStopReg <= wDataHeld[7:0] & `PMC_MASK_CLOCK_STOP;
      end else if (wIdx == `PMC_IDX_THROTTLE_MASK) begin
        throttleReg <= wDataHeld[7:0] & `PMC_MASK_THROTTLE;
      end
    end
  end

  // Read mux; reserved bits read as zero because they are never stored.
  always_comb begin
    readValue = 8'h00;
    readHit = 1'b1;
    if (rIdx == `PMC_IDX_NMI_MASK) begin
      readValue = nmiMaskReg;
    end else if (rIdx == `PMC_IDX_IO_WINDOW) begin
      readValue = ioWindowReg;
    end else if (rIdx == `PMC_IDX_PIN_READBACK) begin
      readValue[`PMC_BIT_MEMORY_PIN] = memoryPowerPin; // RULE1
      readValue[`PMC_BIT_SYSTEM_PIN] = systemPowerPin; // RULE1
      readValue[`PMC_BIT_PANEL_PIN] = panelPowerPin; // RULE1
    end else if (rIdx == `PMC_IDX_DOZE) begin
      readValue = dozeReg;
    end else if (rIdx == `PMC_IDX_SLEEP) begin
      readValue = sleepReg;
    end else if (rIdx == `PMC_IDX_SUSPEND) begin
      readValue = suspendReg;
    end else if (rIdx == `PMC_IDX_ACTIVITY) begin
      readValue = activityReg;
    end else if (rIdx == `PMC_IDX_NMI_PENDING) begin
      readValue = nmiPendingReg;
    end else if (rIdx == `PMC_IDX_RESUME) begin
      readValue = resumeReg;
    end else if (rIdx == `PMC_IDX_CLOCK_STOP) begin
      readValue = clockStopReg;
    end else if (rIdx == `PMC_IDX_THROTTLE_MASK) begin
      readValue = throttleReg;
    end else begin
      readHit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PMC_RESP_OKAY;
    end else begin
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, readValue};
        s_axi_rresp <= readHit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // I/O window match on address bits 9..3; bit 0 of the start is ignored for 16 bytes.
  logic windowHit, windowActivity, anyActivity;
  always_comb begin
    if (ioWindowReg[`PMC_BIT_WINDOW_SIZE]) begin
      windowHit = ioCycle && (ioAddr[9:3] == ioWindowReg[6:0]); // RULE22
    end else begin
      windowHit = ioCycle && (ioAddr[9:4] == ioWindowReg[6:1]); // RULE22
    end
  end

  assign windowActivity = windowHit && !throttleReg[`PMC_BIT_WINDOW_THROTTLE]; // RULE21
  // Only the window has a mask here; the other sources always count as activity.
  assign anyActivity = windowActivity || videoAccess || diskAccess || serialAccess ||
                       cardAccess || keyboardAccess || pinSelectAccess;

  logic [7:0] activitySet;
  logic activityReadClear;
  assign activitySet = {windowHit, videoAccess, diskAccess, 1'b0, serialAccess,
                        cardAccess, keyboardAccess, pinSelectAccess}; // RULE5 RULE7
  assign activityReadClear = doRead && (rIdx == `PMC_IDX_ACTIVITY);

  // A flag set in the same cycle as the clearing read survives for the next read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activityReg <= 8'h00;
    end else if (activityReadClear) begin
      activityReg <= activitySet; // RULE6
    end else begin
      activityReg <= activityReg | activitySet; // RULE5
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      throttleActivity <= 1'b0;
    end else begin
      throttleActivity <= windowActivity; // RULE21
    end
  end

  // Eighth-second tick shared by all idle timers.
  logic [31:0] tickCount;
  logic eighthTick;
  assign eighthTick = (tickCount == EIGHTH_CYC - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= 32'h0;
    end else if (eighthTick) begin
      tickCount <= 32'h0;
    end else begin
      tickCount <= tickCount + 32'h1;
    end
  end

  logic [15:0] timerTarget [3];
  logic [15:0] timerCount [3];
  logic [2:0] timerExpired, timerFire;
  assign timerTarget[0] = dozeTarget(dozeReg[3:0]); // RULE2
  assign timerTarget[1] = minuteTarget(sleepReg[3:0]); // RULE3
  assign timerTarget[2] = minuteTarget(suspendReg[3:0]); // RULE4

  genvar t;
  generate
    for (t = 0; t < 3; t++) begin : g_timer
      assign timerFire[t] = eighthTick && !anyActivity && !timerExpired[t] &&
                            (timerTarget[t] != 16'h0000) &&
                            (timerCount[t] + 16'h0001 >= timerTarget[t]);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          timerCount[t] <= 16'h0000;
          timerExpired[t] <= 1'b0;
        end else if (anyActivity || timerTarget[t] == 16'h0000) begin
          timerCount[t] <= 16'h0000; // RULE24
          timerExpired[t] <= 1'b0;
        end else if (timerFire[t]) begin
          timerExpired[t] <= 1'b1; // RULE24
        end else if (eighthTick && !timerExpired[t]) begin
          timerCount[t] <= timerCount[t] + 16'h0001;
        end
      end
    end
  endgenerate

  assign dozeExpired = timerExpired[0];
  assign sleepExpired = timerExpired[1];
  assign suspendExpired = timerExpired[2];

  // NMI pending capture ignores all masks; delivery is gated separately.
  logic lb1Prev, lb2Prev, extPrev;
  logic [7:0] nmiSet, nmiClear;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {lb1Prev, lb2Prev, extPrev} <= 3'h0;
    end else begin
      {lb1Prev, lb2Prev, extPrev} <= {firstLowBatteryInput, secondLowBatteryInput,
                                      externalPinInput};
    end
  end

  assign nmiSet = {1'b0, sleepWakeEvent, timerFire[2], timerFire[1],
                   secondLowBatteryInput && !lb2Prev, firstLowBatteryInput && !lb1Prev,
                   externalPinInput && !extPrev, 1'b0}; // RULE23
  assign nmiClear = (byteWrite && wIdx == `PMC_IDX_NMI_PENDING) ?
                    wDataHeld[7:0] : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiPendingReg <= 8'h00;
    end else begin
      nmiPendingReg <= (nmiPendingReg & ~nmiClear) | nmiSet; // RULE8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiOut <= 1'b0;
    end else begin
      nmiOut <= !nmiMaskReg[`PMC_BIT_GLOBAL_NMI_BLOCK] && // RULE9 RULE23
                (|(nmiPendingReg & ~nmiMaskReg)); // RULE10
    end
  end

  // Resume sequencer. The system starts out running after reset.
  pmc_resume_e resumeState;
  logic [31:0] resumeCount;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeState <= RS_ON;
      resumeCount <= 32'h0000_0000;
      systemPowerRequest <= 1'b1;
      cpuRestart <= 1'b0;
      beepOnce <= 1'b0;
      beepTwice <= 1'b0;
    end else begin
      cpuRestart <= 1'b0;
      beepOnce <= 1'b0;
      beepTwice <= 1'b0;
      case (resumeState)
        RS_OFF: begin
          if (resumeRequest) begin
            if (resumeReg[`PMC_BIT_WAKE_INHIBIT] && lowBatteryInput) begin
              beepOnce <= resumeReg[`PMC_BIT_BEEP_LB]; // RULE12 RULE14
            end else begin
              resumeState <= RS_POWER_UP;
              resumeCount <= 32'h0000_0000;
              systemPowerRequest <= 1'b1;
            end
          end
        end
        RS_POWER_UP: begin
          if ((resumeReg[`PMC_BIT_LB_CANCEL] && firstLowBatteryInput && !lb1Prev) || // RULE15
              (!supplyGoodInput && resumeReg[`PMC_BIT_PWG_CANCEL] && // RULE16
               resumeCount >= PWG_TIMEOUT_CYC - 1)) begin
            resumeState <= RS_OFF;
            systemPowerRequest <= 1'b0;
            beepTwice <= resumeReg[`PMC_BIT_BEEP_PWG]; // RULE13
          end else if (supplyGoodInput) begin
            resumeCount <= 32'h0;
            if (resumeReg[7:6] == 2'h0) begin
              resumeState <= RS_ON; // RULE11
              cpuRestart <= 1'b1;
            end else begin
              resumeState <= RS_DELAY;
            end
          end else if (resumeCount < PWG_TIMEOUT_CYC) begin
            resumeCount <= resumeCount + 32'h1;
          end
        end
        RS_DELAY: begin
          if (resumeCount + 32'h1 >= restartCycles(resumeReg[7:6])) begin
            resumeState <= RS_ON; // RULE11
            cpuRestart <= 1'b1;
          end else begin
            resumeCount <= resumeCount + 32'h1;
          end
        end
        default: begin
          if (suspendRequest) begin
            resumeState <= RS_OFF;
            systemPowerRequest <= 1'b0;
          end
        end
      endcase
    end
  end

  // CPU clock stop. The halt stop is released by a wake event, never re-armed by it.
  logic haltStopped, expansionStopped, stopEnable, wakeCpu;
  assign stopEnable = clockStopReg[`PMC_BIT_HALT_ENABLE]; // RULE17
  assign wakeCpu = interruptRequest || nmiOut || busHoldRequest;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      haltStopped <= 1'b0;
      expansionStopped <= 1'b0;
      cpuClockStop <= 1'b0;
    end else begin
      if (wakeCpu || !stopEnable || !clockStopReg[`PMC_BIT_HALT_CPU]) begin
        haltStopped <= 1'b0; // RULE20
      end else if (haltCycle) begin
        haltStopped <= 1'b1; // RULE20
      end
      if (internalReady || !stopEnable || !clockStopReg[`PMC_BIT_HALT_EXPANSION]) begin
        expansionStopped <= 1'b0; // RULE19
      end else if (expansionStart) begin
        expansionStopped <= 1'b1; // RULE19
      end
      cpuClockStop <= stopEnable && (haltStopped || expansionStopped || // RULE17
                      (clockStopReg[`PMC_BIT_HALT_GRANT] && busGranted)); // RULE18
    end
  end

endmodule

// ===== dv/pmc_checker_properties.sv
`timescale 1ns/10ps
module pmc_checker (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Sequencing and activity
  input logic resumeRequest,
  input logic supplyGoodInput,
  input logic systemPowerRequest,
  input logic cpuRestart,
  input logic ioCycle,
  input logic throttleActivity,
  input logic videoAccess,
  input logic dozeExpired
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_rresp_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response stuck");
  a_power_cause: assert property ($rose(systemPowerRequest) |-> $past(resumeRequest))
    else $error("power request without wake");
  a_restart_good: assert property (cpuRestart |-> $past(supplyGoodInput))
    else $error("restart without supply good");
  a_throttle_cause: assert property (throttleActivity |-> $past(ioCycle))
    else $error("throttle without access");
  a_activity_clears: assert property (videoAccess |=> !dozeExpired)
    else $error("expiry kept after activity");
endmodule

// ===== dv/pmc_supply_model.sv
`timescale 1ns/10ps
module pmc_supply_model #(
  parameter int LAG = 5
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Rail
  input logic systemPowerRequest,
  output logic supplyGoodInput
);
  int cnt;

  // A rail that is switched off loses its good level at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      supplyGoodInput <= 1'b0;
    end else if (!systemPowerRequest) begin
      cnt <= 0;
      supplyGoodInput <= 1'b0;
    end else if (cnt < LAG) begin
      cnt <= cnt + 1;
    end else begin
      supplyGoodInput <= 1'b1;
    end
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic memoryPowerPin, systemPowerPin, panelPowerPin, ioCycle, sleepWakeEvent, busGranted;
  logic [9:0] ioAddr;
  logic [5:0] act, pv;
  logic videoAccess, diskAccess, serialAccess, cardAccess, keyboardAccess, pinSelectAccess;
  logic firstLowBatteryInput, secondLowBatteryInput, externalPinInput, resumeRequest;
  logic suspendRequest, lowBatteryInput, supplyGoodInput, haltCycle, expansionStart;
  logic internalReady, interruptRequest, busHoldRequest, nmiOut, throttleActivity;
  logic dozeExpired, sleepExpired, suspendExpired, systemPowerRequest, cpuRestart;
  logic beepOnce, beepTwice, cpuClockStop;
  int failures, n_checks, nBeep, nRestart, nThrottle;

  assign {videoAccess, diskAccess, serialAccess, cardAccess, keyboardAccess, pinSelectAccess} = act;
  assign {resumeRequest, suspendRequest, haltCycle, expansionStart, internalReady,
          interruptRequest} = pv;

  pmc_top #(.EIGHTH_CYC(16), .DELAY1_CYC(4), .DELAY2_CYC(8), .DELAY3_CYC(16),
    .PWG_TIMEOUT_CYC(32)) u_pmc_top (.*);
  pmc_supply_model #(.LAG(5)) u_pmc_supply_model (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (beepOnce === 1'b1) nBeep++;
    if (cpuRestart === 1'b1) nRestart++;
    if (throttleActivity === 1'b1) nThrottle++;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
  endtask

  task rchk(input string n, input logic [7:0] i, input logic [7:0] e, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(n, {s_axi_rresp, s_axi_rdata[29:0]}, {r, 22'h0, e});
  endtask

  task kick(input logic [5:0] v);
    @(posedge clk);
    pv <= v;
    @(posedge clk);
    pv <= 6'h00;
    repeat (3) @(posedge clk);
  endtask

  task io(input logic [9:0] a);
    @(posedge clk);
    ioAddr <= a;
    ioCycle <= 1'b1;
    @(posedge clk);
    ioCycle <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task t_reset;
    rchk("readback", 8'hCB, 8'h81, 2'h0);
    rchk("resume", 8'hDD, 8'hC0, 2'h0);
    rchk("throttle", 8'hDF, 8'h80, 2'h0);
    rchk("nmimask", 8'hC4, 8'hBE, 2'h0);
    rchk("sleep", 8'hCD, 8'h00, 2'h0);
    rchk("unmapped", 8'hC0, 8'h00, 2'h2);
    wr(8'hCC, 8'hFF);
    rchk("doze", 8'hCC, 8'h0F, 2'h0);
    $display("test reset done");
  endtask

  task t_activity;
    @(posedge clk);
    act <= 6'h3F;
    @(posedge clk);
    act <= 6'h00;
    rchk("flags", 8'hDB, 8'h6F, 2'h0);
    rchk("cleared", 8'hDB, 8'h00, 2'h0);
    wr(8'hC5, 8'h55);
    io(10'h2AF);
    chk("masked", nThrottle, 0);
    wr(8'hDF, 8'h00);
    io(10'h2A0);
    io(10'h2B0);
    chk("throttle", nThrottle, 1);
    rchk("window", 8'hDB, 8'h80, 2'h0);
    wr(8'hC5, 8'hD5);
    io(10'h2A7);
    rchk("narrow", 8'hDB, 8'h00, 2'h0);
    $display("test activity done");
  endtask

  task t_nmi;
    wr(8'hC4, 8'h3A);
    externalPinInput <= 1'b1;
    secondLowBatteryInput <= 1'b1;
    repeat (3) @(posedge clk);
    chk("masked", nmiOut, 1'b0);
    rchk("pending", 8'hDC, 8'h0A, 2'h0);
    firstLowBatteryInput <= 1'b1;
    repeat (3) @(posedge clk);
    chk("nmi", nmiOut, 1'b1);
    wr(8'hDC, 8'h00);
    chk("kept", nmiOut, 1'b1);
    wr(8'hDC, 8'h04);
    repeat (2) @(posedge clk);
    chk("cleared", nmiOut, 1'b0);
    $display("test nmi done");
  endtask

  task t_resume;
    kick(6'h10);
    chk("off", systemPowerRequest, 1'b0);
    wr(8'hDD, 8'h28);
    lowBatteryInput <= 1'b1;
    kick(6'h20);
    chk("beep", nBeep, 1);
    chk("ignored", systemPowerRequest, 1'b0);
    lowBatteryInput <= 1'b0;
    wr(8'hDD, 8'h40);
    kick(6'h20);
    repeat (3) @(posedge clk);
    chk("early", nRestart, 0);
    repeat (12) @(posedge clk);
    chk("restart", nRestart, 1);
    chk("power", systemPowerRequest, 1'b1);
    $display("test resume done");
  endtask

  task t_clock;
    wr(8'hDE, 8'h03);
    kick(6'h08);
    chk("gated", cpuClockStop, 1'b0);
    kick(6'h01);
    wr(8'hDE, 8'h87);
    kick(6'h08);
    chk("halt", cpuClockStop, 1'b1);
    busHoldRequest <= 1'b1;
    kick(6'h00);
    chk("wake", cpuClockStop, 1'b0);
    kick(6'h04);
    chk("expansion", cpuClockStop, 1'b1);
    kick(6'h02);
    chk("ready", cpuClockStop, 1'b0);
    busGranted <= 1'b1;
    kick(6'h00);
    chk("grant", cpuClockStop, 1'b1);
    $display("test clock done");
  endtask

  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    test_done();
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
    {memoryPowerPin, systemPowerPin, panelPowerPin, ioCycle, sleepWakeEvent} = 5'h14;
    {firstLowBatteryInput, secondLowBatteryInput, externalPinInput, lowBatteryInput} = 4'h0;
    {busGranted, busHoldRequest, ioAddr, act, pv} = 24'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_activity();
    t_nmi();
    t_resume();
    t_clock();
    test_done();
  end
endmodule

bind pmc_top pmc_checker u_pmc_checker (.*);
